// ==== src/gcs_regs.vh ====
// Purpose: Constants for the glitchless clock switchover block.
// Assumes: Included by the switchover design files only.
// Notes: Old hold counts falling edges of the outgoing clock; low and high holds count incoming clock edges.
`ifndef GCS_REGS_VH
`define GCS_REGS_VH
`define GCS_OLD_HOLD 4'h3
`define GCS_LOW_HOLD 4'h3
`define GCS_HIGH_HOLD 4'h2
`define GCS_DEAD_EDGES 4'h4
`define GCS_TOTAL_MAX 5'h11
`define GCS_POR_TIME_NS 32'h0000_03E8
`define GCS_CLK_PERIOD_NS 32'h0000_0019
`endif

// ==== src/gcs_sync.v ====
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_i.
// Notes: First stage feeds only the second stage.
`default_nettype none
module gcs_sync (
  input wire clk_i,
  input wire rst_n_i,
  input wire async_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule // gcs_sync
`default_nettype wire

// ==== src/gcs_switchover.v ====
// Purpose: Glitch-free 2:1 clock switchover with runt guard and fail-safe.
// Assumes: Sampling clock is much faster than both sources.
// Notes: Source levels are sampled; output is a registered clock image.
// What this block does
// - Stuck high: hold output high some alternate pulses.
// - Stuck high: then low for alternate falling edges.
// - Stuck high: then pass alternate clock through.
// - Stretched cycle phases exceed half alternate period.
// - Stuck low: hold low, then pass alternate.
// - Tiny amplitude treated as stuck at last level.
// - Dead input gives stable, defined output level.
// - Slowly degrading toggling input need not be cleaned.
// - Power-on reset puts sequencer in known state.
// - Healthy: follow old, hold low, follow new.
// - Delay pin tied to supply disables guard.
// - Guarded switchover gives up on a slow old clock after 15 alternate clock cycles.
`default_nettype none
`include "gcs_regs.vh"
module gcs_switchover #(
  parameter POR_NS = `GCS_POR_TIME_NS
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire source_a_i,
  input wire source_b_i,
  input wire select_i,
  input wire delay_cap_pin_i,
  input wire failsafe_input_a_ok_i,
  input wire failsafe_input_b_ok_i,
  output reg clk_out_o,
  output reg active_b_o,
  output reg switching_o
);
  localparam [31:0] POR_CYC = (POR_NS + `GCS_CLK_PERIOD_NS - 32'h0000_0001) /
    `GCS_CLK_PERIOD_NS;
  localparam [5:0] ST_RUN = 6'h01;
  localparam [5:0] ST_OLD = 6'h02;
  localparam [5:0] ST_HIGH = 6'h04;
  localparam [5:0] ST_LOW = 6'h08;
  localparam [5:0] ST_POR = 6'h10;
  localparam [5:0] ST_DROP = 6'h20;
  wire a_s;
  wire b_s;
  wire sel_s;
  wire cap_s;
  wire aok_s;
  wire bok_s;
  reg [5:0] state_q;
  reg [5:0] state_d;
  reg cur_b_q;
  reg a_last_q;
  reg b_last_q;
  reg a_valid_q;
  reg b_valid_q;
  reg [3:0] edges_q;
  reg [3:0] dead_q;
  reg [4:0] total_q;
  reg [15:0] por_q;
  reg guard_q;
  reg out_d;
  // Activity and select pass three flops; change counts on agreement.
  gcs_sync u_sa (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
    .async_i(source_a_i), .level_o(a_s));
  gcs_sync u_sb (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
    .async_i(source_b_i), .level_o(b_s));
  gcs_sync u_sel (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
    .async_i(select_i), .level_o(sel_s));
  gcs_sync u_cap (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
    .async_i(delay_cap_pin_i), .level_o(cap_s));
  gcs_sync u_aok (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
    .async_i(failsafe_input_a_ok_i), .level_o(aok_s));
  gcs_sync u_bok (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
    .async_i(failsafe_input_b_ok_i), .level_o(bok_s));
  // Returns the level of a source, frozen while its swing is too small.
  function lvl;
    input ok;
    input live;
    input last;
    begin
      lvl = ok ? live : last;
    end
  endfunction
  wire a_lvl = lvl(aok_s, a_s, a_valid_q);
  wire b_lvl = lvl(bok_s, b_s, b_valid_q);
  wire cur_lvl = cur_b_q ? b_lvl : a_lvl;
  wire cur_last = cur_b_q ? b_last_q : a_last_q;
  wire alt_lvl = cur_b_q ? a_lvl : b_lvl;
  wire alt_last = cur_b_q ? a_last_q : b_last_q;
  wire alt_rise = alt_lvl & ~alt_last;
  wire alt_fall = ~alt_lvl & alt_last;
  wire cur_fall = ~cur_lvl & cur_last;
  wire cur_edge = cur_lvl ^ cur_last;
  wire want_sw = sel_s ^ cur_b_q;
  wire cur_dead = (dead_q >= `GCS_DEAD_EDGES);
  wire timeout = (total_q >= `GCS_TOTAL_MAX - 5'h02);
  always @* begin
    state_d = state_q;
    out_d = clk_out_o;
    case (state_q)
      ST_POR: begin
        out_d = 1'b0;
        // A nonzero budget marks that the wait count was loaded.
        if (por_q == 16'h0000 && total_q != 5'h00) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        out_d = cur_lvl;
        if (want_sw && guard_q) begin
          state_d = ST_OLD;
        end
      end
      ST_OLD: begin
        out_d = cur_lvl;
        if (cur_fall && edges_q >= `GCS_OLD_HOLD) begin
          state_d = ST_LOW;
          out_d = 1'b0;
        end else if (cur_dead || timeout) begin
          // Stuck source: freeze at last level, choose path.
          if (clk_out_o) begin
            state_d = ST_HIGH;
          end else begin
            state_d = ST_LOW;
          end
        end
      end
      ST_HIGH: begin
        out_d = 1'b1;
        if (alt_fall && edges_q >= `GCS_HIGH_HOLD) begin
          state_d = ST_DROP;
          out_d = 1'b0;
        end
      end
      ST_DROP: begin
        state_d = ST_LOW;
        out_d = 1'b0;
      end
      ST_LOW: begin
        out_d = 1'b0;
        if (alt_rise && edges_q >= `GCS_LOW_HOLD) begin
          state_d = ST_RUN;
          out_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_POR;
        out_d = 1'b0;
      end
    endcase
  end
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_POR;
      por_q <= 16'h0000;
      cur_b_q <= 1'b0;
      a_last_q <= 1'b0;
      b_last_q <= 1'b0;
      a_valid_q <= 1'b0;
      b_valid_q <= 1'b0;
      edges_q <= 4'h0;
      dead_q <= 4'h0;
      total_q <= 5'h00;
      guard_q <= 1'b1;
      clk_out_o <= 1'b0;
      active_b_o <= 1'b0;
      switching_o <= 1'b0;
    end else begin
      state_q <= state_d;
      clk_out_o <= out_d;
      a_last_q <= a_lvl;
      b_last_q <= b_lvl;
      if (aok_s) begin
        a_valid_q <= a_s;
      end
      if (bok_s) begin
        b_valid_q <= b_s;
      end
      guard_q <= ~cap_s;
      if (state_q == ST_POR) begin
        if (por_q == 16'h0000 && total_q == 5'h00) begin
          por_q <= POR_CYC[15:0];
          total_q <= 5'h01;
        end else if (por_q != 16'h0000) begin
          por_q <= por_q - 16'h0001;
        end
        cur_b_q <= sel_s;
      end else if (state_q == ST_RUN && want_sw && !guard_q) begin
        cur_b_q <= sel_s;
      end
      if (state_q == ST_RUN && state_d == ST_RUN) begin
        active_b_o <= cur_b_q;
      end
      switching_o <= (state_d != ST_RUN) && (state_d != ST_POR);
      // Stage edge counters restart on each stage change.
      if (state_d != state_q) begin
        edges_q <= 4'h0;
      end else if (state_q == ST_OLD && cur_fall) begin
        edges_q <= edges_q + 4'h1;
      end else if (state_q != ST_OLD && alt_fall) begin
        edges_q <= edges_q + 4'h1;
      end
      // Stuck detection: alternate edges seen without a current edge.
      if (state_q != ST_OLD || cur_edge) begin
        dead_q <= 4'h0;
      end else if (alt_rise && !cur_dead) begin
        dead_q <= dead_q + 4'h1;
      end
      // Whole-switch budget in alternate cycles.
      if (state_q == ST_RUN || state_q == ST_POR) begin
        if (state_q == ST_RUN) begin
          total_q <= 5'h00;
        end
      end else if (alt_rise && total_q != 5'h1F) begin
        total_q <= total_q + 5'h01;
      end
      if (state_q == ST_LOW && state_d == ST_RUN) begin
        cur_b_q <= ~cur_b_q;
        active_b_o <= ~cur_b_q;
      end
    end
  end
endmodule // gcs_switchover
`default_nettype wire

// ==== tb/gcs_props.sv ====
// Purpose: Port assertions for the clock switchover.
// Assumes: Bound to gcs_switchover; one sampling clock.
// Notes: Select is held steady while a switch runs.
`default_nettype none
module gcs_props #(parameter POR_NS = 1000) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic source_a_i,
  input wire logic source_b_i,
  input wire logic select_i,
  input wire logic delay_cap_pin_i,
  input wire logic failsafe_input_a_ok_i,
  input wire logic failsafe_input_b_ok_i,
  input wire logic clk_out_o,
  input wire logic active_b_o,
  input wire logic switching_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_por; $rose(rst_n_i) |-> (!clk_out_o && !switching_o) [*8];
  endproperty
  a_por: assert property (p_por) else $error("busy after reset");
  property p_bound; $rose(switching_o) |-> ##[1:212] !switching_o; endproperty
  a_bound: assert property (p_bound) else $error("switch too long");
  property p_done; $fell(switching_o) |-> active_b_o == select_i; endproperty
  a_done: assert property (p_done) else $error("wrong source");
  property p_stretch; !delay_cap_pin_i && $fell(switching_o) |->
    !$past(clk_out_o, 6) ##[0:1] clk_out_o [*4]; endproperty
  a_stretch: assert property (p_stretch) else $error("short phase");
  property p_sync; !delay_cap_pin_i && !switching_o && $changed(select_i)
    |=> !switching_o; endproperty
  a_sync: assert property (p_sync) else $error("select unsynced");
  property p_bypass; delay_cap_pin_i && $changed(select_i) |->
    ##[1:10] active_b_o == select_i; endproperty
  a_bypass: assert property (p_bypass) else $error("no bypass");
  property p_frozen; (!failsafe_input_b_ok_i && active_b_o && !switching_o)
    [*8] |-> $stable(clk_out_o); endproperty
  a_frozen: assert property (p_frozen) else $error("dead not stable");
  property p_pass; !delay_cap_pin_i && failsafe_input_b_ok_i && active_b_o &&
    !switching_o && $rose(source_b_i) |-> ##[1:7] clk_out_o; endproperty
  a_pass: assert property (p_pass) else $error("not following");
endmodule // gcs_props
`default_nettype wire

// ==== tb/gcs_src_model.sv ====
// Purpose: Two source clocks for the switchover bench.
// Assumes: A source stops at its level while its run input is low.
// Notes: Half periods 125 ns and 150 ns.
`default_nettype none
module gcs_src_model (
  input wire logic run_a_i,
  input wire logic run_b_i,
  output logic src_a_o,
  output logic src_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  assign src_a_o = a_q;
  assign src_b_o = b_q;
  always #125 if (run_a_i) a_q = !a_q;
  always #150 if (run_b_i) b_q = !b_q;
endmodule // gcs_src_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the clock switchover.
// Assumes: Sources come from gcs_src_model.
// Notes: Inputs change at the falling edge.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, rst_n_i = 0, sel = 0, cap = 0, ok_a = 1, ok_b = 1;
  logic run_a = 1, run_b = 1, at_rise;
  wire logic src_a, src_b, clk_out, act_b, sw;
  int fail_count = 0, samples_checked = 0, cyc = 0, n;
  int lo_run, hi_cnt, drops;
  always #12.5 clk_sys_i = !clk_sys_i;
  gcs_src_model u_src (.run_a_i(run_a), .run_b_i(run_b), .src_a_o(src_a),
    .src_b_o(src_b));
  gcs_switchover #(.POR_NS(200)) uut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .source_a_i(src_a), .source_b_i(src_b),
    .select_i(sel), .delay_cap_pin_i(cap), .failsafe_input_a_ok_i(ok_a),
    .failsafe_input_b_ok_i(ok_b), .clk_out_o(clk_out), .active_b_o(act_b),
    .switching_o(sw));
  task automatic end_of_test;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic tick(input int k); repeat (k) @(negedge clk_sys_i); endtask
  task automatic do_switch(input logic s);
    logic prev;
    sel = s;
    for (n = 0; sw !== 1'b1 && n < 50; n++) tick(1);
    chk("switch_start", sw, 1);
    at_rise = clk_out;
    prev = clk_out;
    lo_run = 0;
    hi_cnt = 0;
    drops = 0;
    for (n = 0; sw !== 1'b0 && n < 450; n++) begin
      if (clk_out === 1'b1) begin
        hi_cnt++;
        lo_run = 0;
      end else begin
        lo_run++;
      end
      if (prev === 1'b1 && clk_out === 1'b0) drops++;
      prev = clk_out;
      tick(1);
    end
    chk("switch_time", n <= 212, 1);
  endtask
  task automatic t_healthy;
    do_switch(1);
    chk("healthy_b", act_b, 1);
    chk("healthy_old", drops > 0, 1);
    chk("healthy_low", lo_run > 6, 1);
  endtask
  task automatic t_stuck_high;
    @(posedge src_b);
    tick(2);
    ok_b = 0;
    tick(30);
    chk("frozen_high", clk_out, 1);
    do_switch(0);
    chk("held_high", at_rise, 1);
    chk("high_hold", hi_cnt > 5, 1);
    chk("one_drop", drops == 1, 1);
    chk("low_phase", lo_run > 5, 1);
    chk("stuck_high_a", act_b, 0);
    ok_b = 1;
  endtask
  task automatic t_stuck_low;
    @(negedge src_a);
    tick(1);
    run_a = 0;
    tick(30);
    chk("frozen_low", clk_out, 0);
    do_switch(1);
    chk("held_low", at_rise, 0);
    chk("no_drop", drops == 0, 1);
    chk("low_long", lo_run > 6, 1);
    chk("stuck_low_b", act_b, 1);
    run_a = 1;
  endtask
  task automatic t_bypass;
    cap = 1;
    tick(10);
    sel = 0;
    tick(12);
    chk("bypass_a", act_b, 0);
    chk("bypass_idle", sw, 0);
  endtask
  initial begin
    tick(3);
    rst_n_i = 1;
    tick(2);
    chk("por_out", clk_out, 0);
    tick(60);
    t_healthy;
    t_stuck_high;
    t_stuck_low;
    t_bypass;
    end_of_test;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test;
    end
  end
endmodule // tb_top
bind gcs_switchover gcs_props #(.POR_NS(POR_NS)) u_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .source_a_i(source_a_i),
  .source_b_i(source_b_i), .select_i(select_i),
  .delay_cap_pin_i(delay_cap_pin_i),
  .failsafe_input_a_ok_i(failsafe_input_a_ok_i),
  .failsafe_input_b_ok_i(failsafe_input_b_ok_i), .clk_out_o(clk_out_o),
  .active_b_o(active_b_o), .switching_o(switching_o));
`default_nettype wire
